// *** inc/ris_pkg.sv ***
package ris_pkg;

  // Sequencer timing, in reference-clock cycles (clk_sys is the reference clock)
  localparam int unsigned STAB_CYC          = 4096;
  localparam int unsigned PIN_DRIVE_CYC     = 32;
  localparam int unsigned HOLD_CYC          = 32;
  localparam int unsigned PIN_SAMPLE_CYC    = 32;
  localparam int unsigned MIN_RESET_LOW_CYC = 4;
  localparam int unsigned BUS_DIV           = 4;
  localparam int unsigned NUM_SRC           = 21;

  // Register port map and reset values
  localparam logic [15:0] ADDR_RCS        = 16'h0000;
  localparam logic [15:0] ADDR_CTRL       = 16'h0001;
  localparam logic [15:0] ADDR_WDOG       = 16'hFFFF;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam int unsigned CTRL_STOP_EN    = 0;

  // Vector locations
  localparam logic [15:0] VEC_RESET_HI    = 16'hFFFE;
  localparam logic [15:0] VEC_RESET_LO    = 16'hFFFF;
  localparam logic [15:0] VEC_SWI         = 16'hFFFC;

  // Stacked registers {ccr, a, x, pch, pcl, h}; index high byte is never pushed
  localparam logic [5:0]  STACK_PUSH_SET  = 6'h3E;

  typedef struct packed {
    logic por;
    logic ext;
    logic wdog;
    logic illegal_opcode_flag;
    logic illegal_address_flag;
    logic mon;
    logic lvd;
    logic rsvd;
  } ris_rcs_t;

  localparam logic [7:0] RCS_POWER_UP = 8'h82;

  typedef enum {
    ST_LVD, ST_STAB, ST_PIN, ST_HOLD, ST_EXT, ST_VEC_HI, ST_VEC_LO, ST_VEC_END, ST_RUN
  } ris_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } ris_reg_req_t;

  typedef struct packed {
    logic insn_done;
    logic rti_done;
    logic rti_i_val;
    logic swi_exec;
    logic ill_opcode;
    logic stop_exec;
    logic fetch_unmapped;
    logic mon_entry;
    logic ccr_i_wr;
    logic ccr_i_val;
    logic entry_done;
  } ris_core_evt_t;

  typedef struct packed {
    logic [15:0] vector;
    logic [4:0]  src;
    logic [5:0]  push;
  } ris_int_entry_t;

endpackage

// *** hw/ris_int_arbiter.sv ***
`timescale 1ns/1ps
module ris_int_arbiter #(
  parameter int unsigned N = 21,
  parameter int unsigned W = 5
) (
  input  wire logic [N-1:0] req,
  output logic              valid,
  output logic [W-1:0]      idx
);
  logic [N:0]   hit;
  logic [W-1:0] sel [N+1];

  assign hit[0] = 1'b0;
  assign sel[0] = '0;

  // Lowest index wins: index 0 is the highest priority
  for (genvar i = 0; i < N; i++) begin : g_chain
    assign hit[i+1] = hit[i] | req[i];
    assign sel[i+1] = (req[i] && !hit[i]) ? W'(i) : sel[i];
  end

  assign valid = hit[N];
  assign idx   = sel[N];
endmodule

// *** hw/ris_sequencer.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Internal and pin resets abort the executing instruction at once; low supply one cycle later.
// - After reset, fetch start address from FFFE then FFFF, high byte first.
// - Reset selects a bus clock of reference clock divided by four.
// - Pin held low for minimum time causes external reset and sets its flag.
// - Internal resets drive pin low 32 cycles, then hold 32 more.
// - Power-up stops clocks 4096 cycles with the pin held low.
// - After that delay, pin releases 32 cycles later, vector fetch at 64.
// - Power-up sets power-up and low-supply flags, clears the others.
// - Low supply holds pin low while low, then 4096 delay, sets its flag.
// - Watchdog overflow resets and flags; any write to FFFF restarts it.
// - An illegal opcode resets and sets its flag.
// - Stop instruction with stop disabled counts as an illegal opcode.
// - Opcode fetch from unmapped address resets and flags; data access does not.
// - Status register is read-only; a read, and only a read, clears it.
// - Flags from successive resets accumulate until read.
// - Pin sampled 32 cycles after internal release; low sets external flag.
// - Monitor-entry reset sets its flag.
// - Interrupts never abort an instruction; entry waits for completion.
// - Entry stacks registers, sets mask bit, loads vector; return restores.
// - A latched interrupt cannot be preempted by any other.
// - After each instruction, with mask clear, serve highest pending first.
// - Request pending at return is served before the next main instruction.
// - Entry does not stack the index high byte.
// - Mask bit blocks every source except the software interrupt.
// - Priority 0 is highest; larger numbers are lower priority.
module ris_sequencer #(
  parameter int unsigned WDOG_TIMEOUT_CYC = 262144
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire ris_pkg::ris_reg_req_t   reg_req,
  output logic [7:0]                   reg_rdata,
  input  wire logic                    supply_low,
  input  wire logic                    rst_pin_in,
  output logic                         rst_pin_out,
  output logic                         rst_pin_oe_n,
  input  wire ris_pkg::ris_core_evt_t  core_evt,
  input  wire logic [19:0]             irq_req,
  output logic                         core_hold,
  output logic                         clk_run,
  output logic                         bus_clk_en,
  output logic                         mem_rd,
  output logic [15:0]                  mem_addr,
  input  wire logic [7:0]              mem_rdata,
  output logic                         pc_load,
  output logic [15:0]                  pc_value,
  output logic                         int_entry,
  output ris_pkg::ris_int_entry_t      int_info,
  output logic                         i_mask
);
  import ris_pkg::*;

  ris_state_t     state_q, state_d;
  logic [12:0]    cnt_q, cnt_d;
  logic [2:0]     ext_cnt_q;
  logic [19:0]    wd_q;
  logic [1:0]     div_q;
  ris_rcs_t       rcs_q, rcs_set;
  logic [7:0]     ctrl_q;
  logic           run, wd_ovf, illegal_opcode_flag_fire, int_rst, ext_fire, rd_hit, wd_kick;
  logic           clk_run_q, pin_oe_n_q, mem_rd_q, pc_load_q, busy_q, i_bit_q;
  logic [15:0]    mem_addr_q, pc_q;
  logic [7:0]     rdata_q;
  logic           i_eff, eval, take, arb_valid, int_entry_q;
  logic [4:0]     arb_idx;
  logic [20:0]    req_vec;
  ris_int_entry_t int_info_q;

  assign run       = (state_q == ST_RUN);
  assign wd_ovf    = (wd_q == 20'(WDOG_TIMEOUT_CYC - 1));
  assign illegal_opcode_flag_fire = core_evt.ill_opcode
                   | (core_evt.stop_exec & ~ctrl_q[CTRL_STOP_EN]);
  // Data accesses to unmapped space never reach this block, so they cannot reset
  assign int_rst   = run & (wd_ovf | illegal_opcode_flag_fire | core_evt.fetch_unmapped
                   | core_evt.mon_entry);
  assign ext_fire  = run & ~rst_pin_in
                   & (ext_cnt_q == 3'(MIN_RESET_LOW_CYC - 1));
  assign rd_hit    = reg_req.rd && (reg_req.addr == ADDR_RCS);
  assign wd_kick   = reg_req.wr && (reg_req.addr == ADDR_WDOG);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 13'd1;
    if (supply_low && state_q != ST_LVD) begin
      state_d = ST_LVD;
      cnt_d   = '0;
    end else begin
      case (state_q)
        ST_LVD: begin
          cnt_d = '0;
          if (!supply_low) begin
            state_d = ST_STAB;
          end
        end
        ST_STAB: begin
          if (cnt_q == 13'(STAB_CYC - 1)) begin
            state_d = ST_PIN;
            cnt_d   = '0;
          end
        end
        ST_PIN: begin
          if (cnt_q == 13'(PIN_DRIVE_CYC - 1)) begin
            state_d = ST_HOLD;
            cnt_d   = '0;
          end
        end
        ST_HOLD: begin
          if (cnt_q == 13'(HOLD_CYC - 1)) begin
            state_d = ST_VEC_HI;
            cnt_d   = '0;
          end
        end
        ST_EXT: begin
          cnt_d = '0;
          if (rst_pin_in) begin
            state_d = ST_HOLD;
          end
        end
        ST_VEC_HI:  state_d = ST_VEC_LO;
        ST_VEC_LO:  state_d = ST_VEC_END;
        ST_VEC_END: state_d = ST_RUN;
        ST_RUN: begin
          cnt_d = '0;
          if (int_rst) begin
            state_d = ST_PIN;
          end else if (ext_fire) begin
            state_d = ST_EXT;
          end
        end
        default: state_d = ST_STAB;
      endcase
    end
  end

  // Power-up enters the stabilization delay from the synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= ST_STAB;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Pin and clock gating follow the next state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_oe_n_q <= 1'b0;
      clk_run_q  <= 1'b0;
    end else begin
      pin_oe_n_q <= !(state_d inside {ST_LVD, ST_STAB, ST_PIN});
      clk_run_q  <= !(state_d inside {ST_LVD, ST_STAB});
    end
  end

  // Divider restarts on every reset so the bus always comes up at ref/4
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !clk_run_q || int_rst || ext_fire) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 2'd1;
    end
  end

  // External pin low-time filter, only while running
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run || rst_pin_in || ext_fire) begin
      ext_cnt_q <= '0;
    end else begin
      ext_cnt_q <= ext_cnt_q + 3'd1;
    end
  end

  // Watchdog counter
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run || wd_kick || wd_ovf) begin
      wd_q <= '0;
    end else begin
      wd_q <= wd_q + 20'd1;
    end
  end

  // Reset cause flags: a new cause in the read cycle survives the clear
  always_comb begin
    rcs_set      = '0;
    rcs_set.wdog = run & wd_ovf;
    rcs_set.illegal_opcode_flag = run & illegal_opcode_flag_fire;
    rcs_set.illegal_address_flag = run & core_evt.fetch_unmapped;
    rcs_set.mon  = run & core_evt.mon_entry;
    rcs_set.lvd  = supply_low && state_q != ST_LVD;
    rcs_set.ext  = ext_fire | (state_q == ST_HOLD && !rst_pin_in
                 && cnt_q == 13'(PIN_SAMPLE_CYC - 1));
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rcs_q <= RCS_POWER_UP;
    end else begin
      rcs_q <= (rd_hit ? '0 : rcs_q) | rcs_set;
    end
  end

  // Register port: status is read-only, writes to it are dropped
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_req.wr && reg_req.addr == ADDR_CTRL) begin
      ctrl_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !reg_req.rd) begin
      rdata_q <= '0;
    end else if (reg_req.addr == ADDR_RCS) begin
      rdata_q <= rcs_q;
    end else if (reg_req.addr == ADDR_CTRL) begin
      rdata_q <= ctrl_q;
    end else begin
      rdata_q <= '0;
    end
  end

  // Reset vector fetch, high byte first
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mem_rd_q   <= 1'b0;
      mem_addr_q <= '0;
      pc_q       <= '0;
      pc_load_q  <= 1'b0;
    end else begin
      mem_rd_q   <= (state_d == ST_VEC_HI) || (state_d == ST_VEC_LO);
      mem_addr_q <= (state_d == ST_VEC_HI) ? VEC_RESET_HI : VEC_RESET_LO;
      pc_load_q  <= (state_q == ST_VEC_END);
      if (state_q == ST_VEC_LO) begin
        pc_q[15:8] <= mem_rdata;
      end
      if (state_q == ST_VEC_END) begin
        pc_q[7:0] <= mem_rdata;
      end
    end
  end

  // Interrupt recognition at instruction boundaries only
  assign i_eff   = core_evt.rti_done ? core_evt.rti_i_val : i_bit_q;
  assign req_vec = {irq_req & {20{~i_eff}}, core_evt.swi_exec};
  assign eval    = run && !int_rst && !ext_fire && !busy_q
                 && (core_evt.insn_done || core_evt.rti_done);
  assign take    = eval && arb_valid;

  ris_int_arbiter #(
    .N (NUM_SRC),
    .W (5)
  ) u_arb (
    .req   (req_vec),
    .valid (arb_valid),
    .idx   (arb_idx)
  );

  // Busy blocks any other entry until the core finishes stacking
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      busy_q <= 1'b0;
    end else if (take) begin
      busy_q <= 1'b1;
    end else if (core_evt.entry_done) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      i_bit_q <= 1'b1;
    end else if (take) begin
      i_bit_q <= 1'b1;
    end else if (core_evt.rti_done) begin
      i_bit_q <= core_evt.rti_i_val;
    end else if (core_evt.ccr_i_wr) begin
      i_bit_q <= core_evt.ccr_i_val;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      int_entry_q <= 1'b0;
      int_info_q  <= '0;
    end else begin
      int_entry_q <= take;
      if (take) begin
        int_info_q.vector <= VEC_SWI - {10'h000, arb_idx, 1'b0};
        int_info_q.src    <= arb_idx;
        int_info_q.push   <= STACK_PUSH_SET;
      end
    end
  end

  // Hold is combinational so an internal or pin reset cause stops the core in the same cycle; low supply stops it one cycle later
  assign core_hold    = !run || int_rst || ext_fire;
  assign rst_pin_out  = 1'b0;
  assign rst_pin_oe_n = pin_oe_n_q;
  assign clk_run      = clk_run_q;
  assign bus_clk_en   = clk_run_q && (div_q == 2'(BUS_DIV - 1));
  assign mem_rd       = mem_rd_q;
  assign mem_addr     = mem_addr_q;
  assign pc_load      = pc_load_q;
  assign pc_value     = pc_q;
  assign int_entry    = int_entry_q;
  assign int_info     = int_info_q;
  assign i_mask       = i_bit_q;
  assign reg_rdata    = rdata_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_ABORT_AT_ONCE: assert property (int_rst && !supply_low
    |-> core_hold ##1 state_q == ST_PIN)
    else $error("internal reset did not stop core");
  AST_VEC_ORDER: assert property (state_q == ST_VEC_HI
    |-> mem_rd && mem_addr == VEC_RESET_HI ##1 mem_rd && mem_addr == VEC_RESET_LO
    ##2 pc_load && pc_value[15:8] == $past(mem_rdata, 2))
    else $error("reset vector fetch order wrong");
  AST_BUS_DIV4: assert property (bus_clk_en |=> !bus_clk_en [*3])
    else $error("bus enable faster than ref/4");
  AST_PIN_RELEASE: assert property (state_q == ST_PIN && cnt_q == 13'd31 && !supply_low
    |=> state_q == ST_HOLD && rst_pin_oe_n)
    else $error("pin not released after 32 cycles");
  AST_HOLD_END: assert property (state_q == ST_HOLD && cnt_q == 13'd31 && !supply_low
    |=> state_q == ST_VEC_HI)
    else $error("core hold not 32 cycles");
  AST_STAB_PIN: assert property (state_q == ST_STAB |-> !rst_pin_oe_n && !clk_run)
    else $error("pin or clocks active in stabilization");
  AST_STAB_LEN: assert property (state_q == ST_STAB && cnt_q == 13'd4095 && !supply_low
    |=> state_q == ST_PIN)
    else $error("stabilization delay not 4096");
  AST_POR_FLAGS: assert property ($rose(rst_n) |-> rcs_q == RCS_POWER_UP)
    else $error("power-up flags wrong");
  AST_READ_CLEARS: assert property (rd_hit && rcs_set == '0 |=> rcs_q == '0)
    else $error("read did not clear flags");
  AST_ACCUM: assert property (!rd_hit |=> (rcs_q & $past(rcs_q)) == $past(rcs_q))
    else $error("flag lost without read");
  AST_STOP_ILLEGAL_OPCODE_FLAG: assert property (run && core_evt.stop_exec && !ctrl_q[CTRL_STOP_EN]
    |=> rcs_q.illegal_opcode_flag)
    else $error("disabled stop did not flag");
  AST_MASK_BLOCKS: assert property (take && i_eff |-> arb_idx == 5'd0)
    else $error("masked source taken");
  AST_ENTRY: assert property (take |=> int_entry && i_mask && busy_q)
    else $error("entry did not set mask");
  AST_NO_PREEMPT: assert property (busy_q && !core_evt.entry_done && state_d == ST_RUN
    |=> busy_q && !int_entry)
    else $error("latched interrupt preempted");
  AST_NO_H_PUSH: assert property (int_entry |-> !int_info.push[0])
    else $error("index high byte stacked");

  COV_BOOT: cover property (state_q == ST_VEC_END ##1 run);
  COV_TAKE: cover property (take && arb_idx != 5'd0);
  COV_EXT_SAMPLE: cover property (state_q == ST_HOLD && rcs_set.ext);
  COV_WDOG: cover property (run && wd_ovf);
endmodule

// *** verification/ris_core_model.sv ***
`timescale 1ns/1ps
module ris_core_model #(
  parameter logic [7:0] VEC_HI = 8'h5A,
  parameter logic [7:0] VEC_LO = 8'hC3
) (
  input  wire logic        clk_sys,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  output logic [7:0]       mem_rdata = 8'h00,
  input  wire logic        rst_pin_out,
  input  wire logic        rst_pin_oe_n,
  input  wire logic        ext_low,
  output logic             rst_pin_in
);
  // Pin has a pull-up; either party may pull it low
  assign rst_pin_in = (rst_pin_oe_n | rst_pin_out) & ~ext_low;
  // Outside a read the bus toggles, so a late sample cannot pass by luck
  always @(posedge clk_sys) begin
    if (mem_rd) begin
      mem_rdata <= (mem_addr == 16'hFFFE) ? VEC_HI : (mem_addr == 16'hFFFF) ? VEC_LO : 8'h00;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import ris_pkg::*;
  localparam logic [10:0] INSN = 11'h400, RETURN_FROM_INTERRUPT = 11'h200, SOFTWARE_INTERRUPT_INSTRUCTION = 11'h080, ILL = 11'h040;
  localparam logic [10:0] STOP = 11'h020, FUN = 11'h010, MON = 11'h008, CCRW = 11'h004;
  localparam logic [10:0] DONE = 11'h001;
  logic           clk_sys = 1'b0;
  logic           rst_n = 1'b0;
  ris_reg_req_t   reg_req = '0;
  logic [7:0]     reg_rdata, mem_rdata, rd_v;
  logic           supply_low = 1'b0, ext_low = 1'b0, rst_pin_in, rst_pin_out, rst_pin_oe_n;
  ris_core_evt_t  core_evt = '0;
  logic [19:0]    irq_req = '0;
  logic           core_hold, clk_run, bus_clk_en, mem_rd, pc_load, int_entry, i_mask;
  logic [15:0]    mem_addr, pc_value;
  ris_int_entry_t int_info;
  int             fail_count = 0, samples_checked = 0, cyc = 0;

  always #4 clk_sys = ~clk_sys;

  ris_sequencer #(.WDOG_TIMEOUT_CYC(2000)) ris_sequencer_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .supply_low(supply_low), .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .core_evt(core_evt),
    .irq_req(irq_req), .core_hold(core_hold), .clk_run(clk_run), .bus_clk_en(bus_clk_en),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .pc_load(pc_load),
    .pc_value(pc_value), .int_entry(int_entry), .int_info(int_info), .i_mask(i_mask));

  ris_core_model ris_core_model_inst (.clk_sys(clk_sys), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
    .ext_low(ext_low), .rst_pin_in(rst_pin_in));

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs about 15000 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys) reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys) reg_req <= '0;
  endtask

  task automatic reg_rd(input logic [15:0] a);
    @(posedge clk_sys) reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys) reg_req <= '0;
    @(negedge clk_sys) rd_v = reg_rdata;
  endtask

  task automatic pulse(input logic [10:0] ev);
    @(posedge clk_sys) core_evt <= ris_core_evt_t'(ev);
    @(posedge clk_sys) core_evt <= '0;
  endtask

  // Follows one reset to the start address and measures its phases
  task automatic run_seq(input int exp_low, input int exp_off);
    int lo, off, hi, rn;
    logic [15:0] a0, a1;
    lo = 0;
    off = 0;
    hi = 0;
    rn = 0;
    for (int n = 0; n < 9000 && pc_load !== 1'b1; n++) begin
      @(negedge clk_sys);
      if (rst_pin_oe_n === 1'b0) lo++;
      if (clk_run === 1'b0) off++;
      if (mem_rd === 1'b1) begin
        if (rn == 0) a0 = mem_addr;
        else a1 = mem_addr;
        rn++;
      end else if (rn == 0 && lo > 0 && rst_pin_oe_n === 1'b1) hi++;
    end
    check("pin_low", lo, exp_low);
    check("hold_after_release", hi, HOLD_CYC);
    check("clk_off", off, exp_off);
    check("vec_hi_addr", a0, VEC_RESET_HI);
    check("vec_lo_addr", a1, VEC_RESET_LO);
    check("pc_value", pc_value, 16'h5AC3);
    check("core_hold_run", core_hold, 1'b0);
    reg_wr(ADDR_WDOG, 8'h00);
  endtask

  task automatic expect_status(input logic [7:0] exp);
    reg_rd(ADDR_RCS);
    check("status", rd_v, exp);
  endtask

  task automatic sc_power_up();
    int n;
    run_seq(STAB_CYC + PIN_DRIVE_CYC, STAB_CYC);
    n = 0;
    repeat (16) @(negedge clk_sys) if (bus_clk_en === 1'b1) n++;
    check("bus_clk_pulses", n, 16 / BUS_DIV);
    expect_status(RCS_POWER_UP);
    expect_status(8'h00);
    reg_wr(ADDR_RCS, 8'hFF);
    expect_status(8'h00);
    reg_rd(16'h1234);
    check("unmapped_rd", rd_v, 8'h00);
    check("pin_out", rst_pin_out, 1'b0);
  endtask

  task automatic sc_causes();
    logic [10:0] ev[4] = '{ILL, STOP, FUN, MON};
    logic [7:0] st[4] = '{8'h10, 8'h10, 8'h08, 8'h04};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys) core_evt <= ris_core_evt_t'(ev[i]);
      @(negedge clk_sys) check("abort_hold", core_hold, 1'b1);
      @(posedge clk_sys) core_evt <= '0;
      run_seq(PIN_DRIVE_CYC, 0);
      expect_status(st[i]);
    end
    pulse(ILL);
    run_seq(PIN_DRIVE_CYC, 0);
    pulse(MON);
    run_seq(PIN_DRIVE_CYC, 0);
    expect_status(8'h14);
    reg_wr(ADDR_CTRL, 8'h01);
    pulse(STOP);
    repeat (5) @(negedge clk_sys);
    check("stop_allowed", rst_pin_oe_n, 1'b1);
  endtask

  task automatic sc_watchdog();
    repeat (4) begin
      repeat (1000) @(negedge clk_sys);
      check("kicked_no_reset", rst_pin_oe_n, 1'b1);
      reg_wr(ADDR_WDOG, 8'hA5);
    end
    run_seq(PIN_DRIVE_CYC, 0);
    expect_status(8'h20);
  endtask

  task automatic sc_pin();
    @(posedge clk_sys) ext_low <= 1'b1;
    repeat (MIN_RESET_LOW_CYC + 2) @(posedge clk_sys);
    ext_low <= 1'b0;
    for (int n = 0; n < 300 && pc_load !== 1'b1; n++) @(negedge clk_sys);
    expect_status(8'h40);
    // Pin kept low past the sample point after an internal release
    @(posedge clk_sys) core_evt <= ris_core_evt_t'(ILL);
    ext_low <= 1'b1;
    @(posedge clk_sys) core_evt <= '0;
    // Pin enable only updates after this edge, so look first in the next cycle
    @(negedge clk_sys);
    for (int n = 0; n < 300 && rst_pin_oe_n !== 1'b1; n++) @(negedge clk_sys);
    repeat (PIN_SAMPLE_CYC + 2) @(posedge clk_sys);
    ext_low <= 1'b0;
    for (int n = 0; n < 300 && pc_load !== 1'b1; n++) @(negedge clk_sys);
    expect_status(8'h50);
  endtask

  task automatic sc_supply();
    @(posedge clk_sys) supply_low <= 1'b1;
    repeat (20) @(negedge clk_sys);
    check("low_supply_pin", rst_pin_oe_n, 1'b0);
    check("low_supply_clk", clk_run, 1'b0);
    @(posedge clk_sys) supply_low <= 1'b0;
    // The rise is seen at the next edge; the delay is measured from there
    @(posedge clk_sys);
    run_seq(STAB_CYC + PIN_DRIVE_CYC, STAB_CYC);
    expect_status(8'h02);
  endtask

  task automatic int_step(input logic [10:0] ev, input logic ent, input logic [15:0] vec);
    pulse(ev);
    @(negedge clk_sys);
    check("int_entry", int_entry, ent);
    if (ent) begin
      check("int_vector", int_info.vector, vec);
      check("int_src", int_info.src, (VEC_SWI - vec) >> 1);
      check("int_push", int_info.push, STACK_PUSH_SET);
      check("int_mask", i_mask, 1'b1);
    end
  endtask

  task automatic sc_irq();
    @(posedge clk_sys) irq_req <= 20'h0_0001;
    int_step(INSN, 1'b0, 16'h0000);
    int_step(INSN | SOFTWARE_INTERRUPT_INSTRUCTION, 1'b1, VEC_SWI);
    int_step(INSN, 1'b0, 16'h0000);
    int_step(DONE, 1'b0, 16'h0000);
    int_step(CCRW, 1'b0, 16'h0000);
    @(posedge clk_sys) irq_req <= 20'h0_000A;
    int_step(11'h000, 1'b0, 16'h0000);
    int_step(INSN, 1'b1, 16'hFFF8);
    int_step(DONE, 1'b0, 16'h0000);
    @(posedge clk_sys) irq_req <= 20'h0_0008;
    int_step(RETURN_FROM_INTERRUPT, 1'b1, 16'hFFF4);
    int_step(DONE, 1'b0, 16'h0000);
    int_step(RETURN_FROM_INTERRUPT | 11'h100, 1'b0, 16'h0000);
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    sc_power_up();
    sc_causes();
    sc_pin();
    sc_supply();
    sc_irq();
    sc_watchdog();
    give_verdict();
  end
endmodule
